// *** dcr_l1dc_ctrl.sv ***
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "dcr_defs.svh"
// How it works
// - One request stage feeds translation and cache strictly in program order.
// - Loads pass checked stores only when their granules differ.
// - Accesses matching the queued miss granule stall until it completes.
// - Load-reserve loads the word and reserves its aligned 32-byte granule.
// - Every non-faulting store-conditional from this core cancels the reservation.
// - Snooped foreign write or invalidate to the granule cancels the reservation.
// - Store-conditional checks only reservation existence; failure clears success flag.
// - Load-reserve miss fills a block if cacheable, else single-beat load.
// - Reserve and conditional bus operations carry their own transfer types.
// - Store-conditional is always write-through; only the page inhibit attribute is passed on.
// - L2 hit completes store-conditional there; a miss goes to the bus.
// - Successful store-conditional updates a hitting line and sets the flag.
// - No reservation: store-conditional ends with no transaction, caches untouched.
// - Hard reset invalidates the data cache only; soft reset keeps contents.
// - Flash-invalidate bit invalidates, self-clears next clock when cache enabled.
// - Data cache enable resets to zero.
// - Disabled cache ignores tags on loads and stores; those go out single-beat.
// - Cache-inhibit output always follows the page inhibit attribute.
// - No snooping of cache tags while the data cache is disabled.
// - Disabled: block-zero faults, touch is no-op, flush/store/invalidate still act.
// - Locked: hits served, misses go single-beat without allocation.
// - Locked cache snoops like unlocked; killed lines stay invalid while locked.
module dcr_l1dc_ctrl (
   // Clock and resets
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        soft_rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wstrb,
   input  wire logic        reg_rstrb,
   output logic      [31:0] reg_rdata,
   // Load/store pipeline requests
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [3:0]  req_op,
   input  wire logic [31:0] req_addr,
   input  wire logic [3:0]  page_attr_bits,
   input  wire logic        req_fault,
   // Load/store pipeline answers
   output logic             rsp_valid,
   output logic             rsp_fault,
   output logic             rsp_align_exc,
   output logic             sc_done,
   output logic             store_success_flag,
   output logic             l1_update,
   // L2 / system bus request
   output logic             mem_req_valid,
   output logic      [31:0] mem_req_addr,
   output logic      [4:0]  mem_req_ttype,
   output logic             mem_req_burst,
   output logic             mem_req_write,
   output logic             cache_inhibit_attr_out,
   input  wire logic        mem_done,
   input  wire logic        mem_ok,
   // Snooped bus traffic from other masters
   input  wire logic        snoop_valid,
   input  wire logic        snoop_global,
   input  wire logic        snoop_kill,
   input  wire logic [31:0] snoop_addr,
   // Instruction cache control
   output logic             icache_flash_invalidate
);

   dcr_pkg::dcr_top_s r_reg;
   dcr_pkg::dcr_top_s r_next;

   dcr_resv_if rif ();

   logic [2:0]  s_idx;
   logic [23:0] s_tag;
   logic        tag_hit;
   logic        inhib;
   logic        hit;
   logic        q_match;
   logic [2:0]  sn_idx;
   logic        sn_hit;
   logic [2:0]  m_idx;
   logic        m_hit;
   logic        set_resv;
   logic        sc_cancel;
   logic        s_done;
   logic [7:0]  line_hit;

   // Reservation keeper
   dcr_resv u_resv (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .rif     (rif)
   );

   // Per-line tag compare
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_line
         assign line_hit[gi] = r_reg.vld[gi] && (r_reg.tag[gi] == s_tag);
      end
   endgenerate

   // Lookup of the staged access
   assign s_idx   = r_reg.s_addr[7:5];
   assign s_tag   = r_reg.s_addr[31:8];
   assign tag_hit = line_hit[s_idx];
   assign inhib   = r_reg.s_attr[`DCR_ATTR_I];
   assign hit     = r_reg.dce && tag_hit && !inhib;
   assign q_match = r_reg.mreq && (r_reg.maddr[31:5] == r_reg.s_addr[31:5]);

   // Snoop and fill lookups
   assign sn_idx = snoop_addr[7:5];
   assign sn_hit = r_reg.vld[sn_idx] && (r_reg.tag[sn_idx] == snoop_addr[31:8]);
   assign m_idx  = r_reg.maddr[7:5];
   assign m_hit  = r_reg.vld[m_idx] && (r_reg.tag[m_idx] == r_reg.maddr[31:8]);

   // Reservation unit hookup
   assign rif.set       = set_resv;
   assign rif.set_gran  = r_reg.s_addr[31:`DCR_GRAN_LSB];
   assign rif.sc_cancel = sc_cancel;
   assign rif.drop      = soft_rst;
   assign rif.snp_kill  = snoop_valid && snoop_global && snoop_kill;
   assign rif.snp_gran  = snoop_addr[31:`DCR_GRAN_LSB];

   // Next-state logic
   always_comb begin
      r_next           = r_reg;
      set_resv         = 1'b0;
      sc_cancel        = 1'b0;
      s_done           = 1'b0;
      r_next.rsp_valid = 1'b0;
      r_next.rsp_fault = 1'b0;
      r_next.rsp_align = 1'b0;
      r_next.sc_done   = 1'b0;
      r_next.l1_upd    = 1'b0;
      r_next.rdata     = '0;

      // Staged access in program order
      if (r_reg.s_vld) begin
         if (r_reg.s_fault) begin
            r_next.rsp_valid = 1'b1;
            r_next.rsp_fault = 1'b1;
            s_done           = 1'b1;
         end else begin
            case (r_reg.s_op)
               dcr_pkg::DCR_OP_LOAD, dcr_pkg::DCR_OP_LWARX: begin
                  if (q_match) begin
                     s_done = 1'b0;
                  end else if (hit) begin
                     set_resv         = (r_reg.s_op == dcr_pkg::DCR_OP_LWARX);
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end else if (!r_reg.mreq) begin
                     set_resv       = (r_reg.s_op == dcr_pkg::DCR_OP_LWARX);
                     r_next.mreq    = 1'b1;
                     r_next.maddr   = r_reg.s_addr;
                     r_next.mwrite  = 1'b0;
                     r_next.mci     = inhib;
                     r_next.mburst  = r_reg.dce && !r_reg.dcache_lock && !inhib;
                     r_next.q_alloc = r_reg.dce && !r_reg.dcache_lock && !inhib;
                     r_next.q_resp  = 1'b1;
                     r_next.q_op    = r_reg.s_op;
                     if (r_reg.s_op == dcr_pkg::DCR_OP_LWARX) begin
                        r_next.mttype = (r_reg.dce && !r_reg.dcache_lock && !inhib) ?
                                        `DCR_TT_RWITM_ATOM : `DCR_TT_READ_ATOM;
                     end else begin
                        r_next.mttype = (r_reg.dce && !r_reg.dcache_lock && !inhib) ?
                                        `DCR_TT_RWITM : `DCR_TT_READ;
                     end
                     s_done = 1'b1;
                  end
               end
               dcr_pkg::DCR_OP_STORE: begin
                  if (q_match) begin
                     s_done = 1'b0;
                  end else if (hit && !r_reg.s_attr[`DCR_ATTR_W]) begin
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end else if (!r_reg.mreq) begin
                     r_next.mreq      = 1'b1;
                     r_next.maddr     = r_reg.s_addr;
                     r_next.mwrite    = 1'b1;
                     r_next.mci       = inhib;
                     r_next.mburst    = 1'b0;
                     r_next.mttype    = `DCR_TT_WRITE;
                     r_next.q_alloc   = 1'b0;
                     r_next.q_resp    = 1'b0;
                     r_next.q_op      = r_reg.s_op;
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end
               end
               dcr_pkg::DCR_OP_STWCX: begin
                  if (!r_reg.mreq) begin
                     sc_cancel = 1'b1;
                     if (!rif.held) begin
                        r_next.sc_done   = 1'b1;
                        r_next.succ      = 1'b0;
                        r_next.rsp_valid = 1'b1;
                     end else begin
                        r_next.mreq    = 1'b1;
                        r_next.maddr   = r_reg.s_addr;
                        r_next.mwrite  = 1'b1;
                        r_next.mci     = inhib;
                        r_next.mburst  = 1'b0;
                        r_next.mttype  = `DCR_TT_WRITE_COND;
                        r_next.q_alloc = 1'b0;
                        r_next.q_resp  = 1'b1;
                        r_next.q_op    = r_reg.s_op;
                     end
                     s_done = 1'b1;
                  end
               end
               dcr_pkg::DCR_OP_DCBZ: begin
                  if (!r_reg.dce || inhib || r_reg.s_attr[`DCR_ATTR_W]) begin
                     r_next.rsp_valid = 1'b1;
                     r_next.rsp_align = 1'b1;
                     s_done           = 1'b1;
                  end else if (!q_match) begin
                     if (!tag_hit && !r_reg.dcache_lock) begin
                        r_next.vld[s_idx] = 1'b1;
                        r_next.tag[s_idx] = s_tag;
                     end
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end
               end
               dcr_pkg::DCR_OP_DCBT: begin
                  if (!r_reg.dce || hit || inhib || r_reg.dcache_lock) begin
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end else if (!q_match && !r_reg.mreq) begin
                     r_next.mreq      = 1'b1;
                     r_next.maddr     = r_reg.s_addr;
                     r_next.mwrite    = 1'b0;
                     r_next.mci       = inhib;
                     r_next.mburst    = 1'b1;
                     r_next.mttype    = `DCR_TT_RWITM;
                     r_next.q_alloc   = 1'b1;
                     r_next.q_resp    = 1'b0;
                     r_next.q_op      = r_reg.s_op;
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end
               end
               dcr_pkg::DCR_OP_DCBF, dcr_pkg::DCR_OP_DCBST, dcr_pkg::DCR_OP_DCBI: begin
                  if (!r_reg.mreq) begin
                     if (tag_hit && (r_reg.s_op != dcr_pkg::DCR_OP_DCBST)) begin
                        r_next.vld[s_idx] = 1'b0;
                     end
                     r_next.mreq      = 1'b1;
                     r_next.maddr     = r_reg.s_addr;
                     r_next.mwrite    = 1'b0;
                     r_next.mci       = inhib;
                     r_next.mburst    = 1'b0;
                     r_next.mttype    = `DCR_TT_ADDR_ONLY;
                     r_next.q_alloc   = 1'b0;
                     r_next.q_resp    = 1'b0;
                     r_next.q_op      = r_reg.s_op;
                     r_next.rsp_valid = 1'b1;
                     s_done           = 1'b1;
                  end
               end
               default: begin
                  r_next.rsp_valid = 1'b1;
                  s_done           = 1'b1;
               end
            endcase
         end
      end
      if (s_done) begin
         r_next.s_vld = 1'b0;
      end

      // Queued request completes
      if (r_reg.mreq && mem_done) begin
         r_next.mreq = 1'b0;
         if (r_reg.q_alloc && mem_ok && !r_reg.dcache_lock) begin
            r_next.vld[m_idx] = 1'b1;
            r_next.tag[m_idx] = r_reg.maddr[31:8];
         end
         if (r_reg.q_op == dcr_pkg::DCR_OP_STWCX) begin
            r_next.sc_done   = 1'b1;
            r_next.succ      = mem_ok;
            r_next.l1_upd    = mem_ok && m_hit && r_reg.dce;
            r_next.rsp_valid = 1'b1;
         end else if (r_reg.q_resp) begin
            r_next.rsp_valid = 1'b1;
         end
      end

      // Take next access into the stage
      if (r_reg.req_ready && req_valid) begin
         r_next.s_vld   = 1'b1;
         r_next.s_op    = dcr_pkg::dcr_op_e'(req_op);
         r_next.s_addr  = req_addr;
         r_next.s_attr  = page_attr_bits;
         r_next.s_fault = req_fault;
      end

      // Snoop kill; lock ignored
      if (r_reg.dce && snoop_valid && snoop_global && snoop_kill && sn_hit) begin
         r_next.vld[sn_idx] = 1'b0;
      end

      // Flash invalidate, self-clear when enabled
      if (r_reg.dfi) begin
         r_next.vld = '0;
         if (r_reg.dce) begin
            r_next.dfi = 1'b0;
         end
      end
      if (r_reg.ifi && r_reg.ice) begin
         r_next.ifi = 1'b0;
      end

      // Register writes; a late clear is harmless
      if (reg_wstrb) begin
         if (reg_addr == `DCR_OFF_HWCFG) begin
            r_next.dce   = reg_wdata[`DCR_BIT_DCE];
            r_next.ice   = reg_wdata[`DCR_BIT_ICE];
            r_next.dcache_lock = reg_wdata[`DCR_BIT_DCACHE_LOCK];
            r_next.dfi   = reg_wdata[`DCR_BIT_DCACHE_FLASH_INVALIDATE];
            r_next.ifi   = reg_wdata[`DCR_BIT_ICACHE_FLASH_INVALIDATE];
         end
      end

      // Register reads, data next cycle
      if (reg_rstrb) begin
         if (reg_addr == `DCR_OFF_HWCFG) begin
            r_next.rdata[`DCR_BIT_DCE]   = r_reg.dce;
            r_next.rdata[`DCR_BIT_ICE]   = r_reg.ice;
            r_next.rdata[`DCR_BIT_DCACHE_LOCK] = r_reg.dcache_lock;
            r_next.rdata[`DCR_BIT_DCACHE_FLASH_INVALIDATE]  = r_reg.dfi;
            r_next.rdata[`DCR_BIT_ICACHE_FLASH_INVALIDATE]  = r_reg.ifi;
         end else if (reg_addr == `DCR_OFF_STATUS) begin
            r_next.rdata[`DCR_BIT_ST_RESV]  = rif.held;
            r_next.rdata[`DCR_BIT_ST_QBUSY] = r_reg.mreq;
            r_next.rdata[`DCR_BIT_ST_SBUSY] = r_reg.s_vld;
            r_next.rdata[`DCR_BIT_ST_DFI]   = r_reg.dfi;
         end else if (reg_addr == `DCR_OFF_RESV) begin
            r_next.rdata = {rif.held_gran, 5'h00};
         end else begin
            r_next.rdata = '0;
         end
      end

      // Soft reset keeps cache contents
      if (soft_rst) begin
         r_next.s_vld     = 1'b0;
         r_next.mreq      = 1'b0;
         r_next.rsp_valid = 1'b0;
         r_next.sc_done   = 1'b0;
         r_next.l1_upd    = 1'b0;
      end
      r_next.req_ready = !r_next.s_vld && !soft_rst;
   end

   // State register; hard reset invalidates the data cache only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg       <= '0;
         r_reg.dce   <= `DCR_CFG_RST;
         r_reg.ice   <= `DCR_CFG_RST;
         r_reg.dcache_lock <= `DCR_CFG_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // Registered outputs
   assign reg_rdata               = r_reg.rdata;
   assign req_ready               = r_reg.req_ready;
   assign rsp_valid               = r_reg.rsp_valid;
   assign rsp_fault               = r_reg.rsp_fault;
   assign rsp_align_exc           = r_reg.rsp_align;
   assign sc_done                 = r_reg.sc_done;
   assign store_success_flag      = r_reg.succ;
   assign l1_update               = r_reg.l1_upd;
   assign mem_req_valid           = r_reg.mreq;
   assign mem_req_addr            = r_reg.maddr;
   assign mem_req_ttype           = r_reg.mttype;
   assign mem_req_burst           = r_reg.mburst;
   assign mem_req_write           = r_reg.mwrite;
   assign cache_inhibit_attr_out  = r_reg.mci;
   assign icache_flash_invalidate = r_reg.ifi;

endmodule

// *** dcr_defs.svh ***
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// Register offsets
`define DCR_OFF_HWCFG      4'h0
`define DCR_OFF_STATUS     4'h4
`define DCR_OFF_RESV       4'h8

// hardware_config_reg fields
`define DCR_BIT_DCE        0
`define DCR_BIT_ICE        1
`define DCR_BIT_DCACHE_LOCK      2
`define DCR_BIT_DCACHE_FLASH_INVALIDATE       3
`define DCR_BIT_ICACHE_FLASH_INVALIDATE       4

// Status register fields
`define DCR_BIT_ST_RESV    0
`define DCR_BIT_ST_QBUSY   1
`define DCR_BIT_ST_SBUSY   2
`define DCR_BIT_ST_DFI     3

// Configuration reset value
`define DCR_CFG_RST        1'b0

// Page attribute bits
`define DCR_ATTR_W         3
`define DCR_ATTR_I         2

// 32-byte reservation granule
`define DCR_GRAN_LSB       5

// Bus transfer types
`define DCR_TT_READ        5'h0a
`define DCR_TT_RWITM       5'h0e
`define DCR_TT_WRITE       5'h02
`define DCR_TT_ADDR_ONLY   5'h04
`define DCR_TT_READ_ATOM   5'h1a
`define DCR_TT_RWITM_ATOM  5'h1e
`define DCR_TT_WRITE_COND  5'h06

`endif

// *** dcr_pkg.sv ***
package dcr_pkg;

   // Memory access operations from the load/store pipeline
   typedef enum logic [3:0] {
      DCR_OP_LOAD  = 4'h0,
      DCR_OP_STORE = 4'h1,
      DCR_OP_LWARX = 4'h2,
      DCR_OP_STWCX = 4'h3,
      DCR_OP_DCBZ  = 4'h4,
      DCR_OP_DCBT  = 4'h5,
      DCR_OP_DCBF  = 4'h6,
      DCR_OP_DCBST = 4'h7,
      DCR_OP_DCBI  = 4'h8
   } dcr_op_e;

   // Reservation unit state
   typedef struct packed {
      logic        held;
      logic [26:0] gran;
   } dcr_resv_s;

   // Controller state
   typedef struct packed {
      logic              dce;
      logic              ice;
      logic              dcache_lock;
      logic              dfi;
      logic              ifi;
      logic [7:0]        vld;
      logic [7:0][23:0]  tag;
      logic              s_vld;
      dcr_op_e           s_op;
      logic [31:0]       s_addr;
      logic [3:0]        s_attr;
      logic              s_fault;
      logic              mreq;
      dcr_op_e           q_op;
      logic              q_alloc;
      logic              q_resp;
      logic [31:0]       maddr;
      logic [4:0]        mttype;
      logic              mburst;
      logic              mwrite;
      logic              mci;
      logic              req_ready;
      logic              rsp_valid;
      logic              rsp_fault;
      logic              rsp_align;
      logic              sc_done;
      logic              succ;
      logic              l1_upd;
      logic [31:0]       rdata;
   } dcr_top_s;

endpackage

// *** dcr_resv_if.sv ***
`timescale 1ns/1ns
interface dcr_resv_if;
   logic        set;
   logic [26:0] set_gran;
   logic        sc_cancel;
   logic        drop;
   logic        snp_kill;
   logic [26:0] snp_gran;
   logic        held;
   logic [26:0] held_gran;

   // Reservation keeper
   modport owner (input set, set_gran, sc_cancel, drop, snp_kill, snp_gran,
                  output held, held_gran);
   // Controller side
   modport user  (output set, set_gran, sc_cancel, drop, snp_kill, snp_gran,
                  input held, held_gran);
endinterface

// *** dcr_resv.sv ***
`timescale 1ns/1ns
module dcr_resv (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   // Controller link
   dcr_resv_if.owner rif
);

   dcr_pkg::dcr_resv_s r_reg;
   dcr_pkg::dcr_resv_s r_next;

   // New set wins over any cancel
   always_comb begin
      r_next = r_reg;
      if (rif.drop || rif.sc_cancel) begin
         r_next.held = 1'b0;
      end
      if (rif.snp_kill && r_reg.held && (rif.snp_gran == r_reg.gran)) begin
         r_next.held = 1'b0;
      end
      if (rif.set) begin
         r_next.held = 1'b1;
         r_next.gran = rif.set_gran;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Only existence matters to the conditional store
   assign rif.held      = r_reg.held;
   assign rif.held_gran = r_reg.gran;

endmodule

// *** dcr_l1dc_properties.sv ***
`timescale 1ns/1ns
`include "dcr_defs.svh"
module dcr_l1dc_props (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       nrst,
   // Pipeline side
   input wire logic       req_valid,
   input wire logic       req_ready,
   input wire logic       rsp_valid,
   input wire logic       sc_done,
   input wire logic       store_success_flag,
   input wire logic       l1_update,
   // Memory side
   input wire logic       mem_req_valid,
   input wire logic [4:0] mem_req_ttype,
   input wire logic       mem_req_burst,
   input wire logic       cache_inhibit_attr_out,
   input wire logic       mem_done
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Pipeline and memory relations
   property p_take_gap; req_valid && req_ready |=> !req_ready; endproperty
   property p_hold;
      mem_req_valid && !mem_done |=> mem_req_valid && $stable(cache_inhibit_attr_out);
   endproperty
   property p_release; mem_req_valid && mem_done |=> !mem_req_valid; endproperty
   property p_burst;
      mem_req_valid && mem_req_burst |-> !cache_inhibit_attr_out
         && (mem_req_ttype == `DCR_TT_RWITM || mem_req_ttype == `DCR_TT_RWITM_ATOM);
   endproperty
   property p_sc_single;
      mem_req_valid && mem_req_ttype == `DCR_TT_WRITE_COND |-> !mem_req_burst;
   endproperty
   property p_sc_rsp; sc_done |-> rsp_valid; endproperty
   property p_upd; l1_update |-> sc_done && store_success_flag; endproperty
   property p_succ; sc_done && store_success_flag |-> $past(mem_done); endproperty
   a_take_gap: assert property (p_take_gap) else $error("ready stayed high after take");
   a_hold: assert property (p_hold) else $error("memory request changed while open");
   a_release: assert property (p_release) else $error("request held after done");
   a_burst: assert property (p_burst) else $error("bad burst request");
   a_sc_single: assert property (p_sc_single) else $error("conditional store burst");
   a_sc_rsp: assert property (p_sc_rsp) else $error("conditional end without answer");
   a_upd: assert property (p_upd) else $error("line update without success");
   a_succ: assert property (p_succ) else $error("success without completion");
   // Scenarios
   c_succ: cover property (sc_done && store_success_flag);
   c_fail: cover property (sc_done && !store_success_flag);
   c_burst: cover property (mem_req_valid && mem_req_burst);
endmodule
bind dcr_l1dc_ctrl dcr_l1dc_props u_props (.*);

// *** dcr_mem_model.sv ***
`timescale 1ns/1ns
module dcr_mem_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Request from the block and answer control
   input  wire logic       mem_req_valid,
   input  wire logic [3:0] lat,
   input  wire logic       ok,
   // Completion
   output logic            mem_done,
   output logic            mem_ok
);
   logic [3:0] cnt;
   // Done after lat waits; outcome inverted off done
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 4'h0;
         mem_done <= 1'b0;
         mem_ok <= 1'b0;
      end else if (mem_req_valid && !mem_done && cnt == lat) begin
         cnt <= 4'h0;
         mem_done <= 1'b1;
         mem_ok <= ok;
      end else begin
         cnt <= (mem_req_valid && !mem_done) ? cnt + 4'h1 : 4'h0;
         mem_done <= 1'b0;
         mem_ok <= ~ok;
      end
   end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "dcr_defs.svh"
module tb_top;
   logic        ref_clk = 1'b0, nrst = 1'b0, reg_wstrb = 1'b0, reg_rstrb = 1'b0, ok = 1'b1;
   logic        req_valid = 1'b0, snoop_valid = 1'b0, snoop_kill = 1'b1, mv_q = 1'b0;
   logic        sc, fl, al, gr, bu, ci, req_ready, rsp_valid, rsp_align_exc, sc_done;
   logic        store_success_flag, l1_update, mem_req_valid, mem_req_burst, mem_done, mem_ok;
   logic        cache_inhibit_attr_out;
   logic [3:0]  reg_addr = 4'h0, req_op = 4'h0, page_attr_bits = 4'h0, lat = 4'h1;
   logic [31:0] reg_wdata = 32'h0, req_addr = 32'h0, snoop_addr = 32'h0, reg_rdata;
   logic [4:0]  mem_req_ttype, tt;
   int          bad_count = 0, n_tests = 0, cyc = 0, mcnt = 0;
   dcr_l1dc_ctrl uut (.ref_clk, .nrst, .soft_rst(1'b0), .reg_addr, .reg_wdata, .reg_wstrb,
      .reg_rstrb, .reg_rdata, .req_valid, .req_ready, .req_op, .req_addr, .page_attr_bits,
      .req_fault(1'b0), .rsp_valid, .rsp_fault(), .rsp_align_exc, .sc_done,
      .store_success_flag, .l1_update, .mem_req_valid, .mem_req_addr(), .mem_req_ttype,
      .mem_req_burst, .mem_req_write(), .cache_inhibit_attr_out, .mem_done, .mem_ok,
      .snoop_valid, .snoop_global(snoop_valid), .snoop_kill, .snoop_addr,
      .icache_flash_invalidate());
   dcr_mem_model far_end (.ref_clk, .nrst, .mem_req_valid, .lat, .ok, .mem_done, .mem_ok);
   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   // Hang guard, request capture
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         report_and_stop();
      end
      if (mem_req_valid && !mv_q) begin
         mcnt++;
         tt = mem_req_ttype;
         bu = mem_req_burst;
         ci = cache_inhibit_attr_out;
      end
      mv_q = mem_req_valid;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Register write and read
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wstrb <= 1'b1;
      @(posedge ref_clk);
      reg_wstrb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rstrb <= 1'b1;
      @(posedge ref_clk);
      reg_rstrb <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   // One pipeline access
   task automatic acc(input logic [3:0] op, input logic [31:0] a, input logic [3:0] at);
      {sc, fl, al, gr} = 4'h0;
      mcnt = 0;
      @(posedge ref_clk);
      while (req_ready !== 1'b1) @(posedge ref_clk);
      req_op <= op;
      req_addr <= a;
      page_attr_bits <= at;
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      repeat (60) begin
         @(posedge ref_clk);
         #1;
         if (rsp_valid === 1'b1) begin
            {sc, fl, al, gr} = {sc_done, store_success_flag, rsp_align_exc, 1'b1};
            break;
         end
      end
      check(gr, 1'b1);
   endtask
   // Foreign bus write
   task automatic snoop(input logic [31:0] a);
      @(posedge ref_clk);
      snoop_valid <= 1'b1;
      snoop_addr <= a;
      @(posedge ref_clk);
      snoop_valid <= 1'b0;
   endtask
   task automatic t_reset();
      rd(`DCR_OFF_HWCFG, 32'h0);
      rd(`DCR_OFF_STATUS, 32'h0);
      rd(4'hc, 32'h0);
      acc(4'h3, 32'h100, 4'h0);
      check({sc, fl}, 2'b10);
      check(mcnt, 0);
      $display("test reset done");
   endtask
   task automatic t_resv();
      wr(`DCR_OFF_HWCFG, 32'h1);
      acc(4'h2, 32'h1234_5678, 4'h0);
      check({tt, bu}, {`DCR_TT_RWITM_ATOM, 1'b1});
      rd(`DCR_OFF_STATUS, 32'h1);
      rd(`DCR_OFF_RESV, 32'h1234_5660);
      lat = 4'h6;
      acc(4'h3, 32'h40, 4'hc);
      check({tt, bu, ci}, {`DCR_TT_WRITE_COND, 2'b01});
      check({sc, fl}, 2'b11);
      rd(`DCR_OFF_STATUS, 32'h0);
      lat = 4'h1;
      acc(4'h0, 32'h1234_5678, 4'h0);
      check(mcnt, 0);
      wr(`DCR_OFF_HWCFG, 32'h9);
      rd(`DCR_OFF_HWCFG, 32'h1);
      wr(`DCR_OFF_HWCFG, 32'h1);
      acc(4'h0, 32'h1234_5678, 4'h0);
      check(mcnt, 1);
      $display("test reservation done");
   endtask
   task automatic t_snoop();
      acc(4'h2, 32'h2000, 4'h4);
      check({tt, bu, ci}, {`DCR_TT_READ_ATOM, 2'b01});
      snoop(32'h2020);
      rd(`DCR_OFF_STATUS, 32'h1);
      snoop(32'h201c);
      rd(`DCR_OFF_STATUS, 32'h0);
      acc(4'h3, 32'h2000, 4'h0);
      check({sc, fl, 28'(mcnt)}, 30'h2000_0000);
      $display("test snoop done");
   endtask
   task automatic t_modes();
      wr(`DCR_OFF_HWCFG, 32'h8);
      rd(`DCR_OFF_HWCFG, 32'h8);
      wr(`DCR_OFF_HWCFG, 32'h0);
      acc(4'h4, 32'h300, 4'h0);
      check(al, 1'b1);
      acc(4'h5, 32'h300, 4'h0);
      check(mcnt, 0);
      acc(4'h0, 32'h1234_5678, 4'h0);
      check({tt, bu}, {`DCR_TT_READ, 1'b0});
      wr(`DCR_OFF_HWCFG, 32'h5);
      acc(4'h2, 32'h600, 4'h0);
      check({tt, bu}, {`DCR_TT_READ_ATOM, 1'b0});
      acc(4'h0, 32'h600, 4'h0);
      check(mcnt, 1);
      $display("test modes done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_reset();
      t_resv();
      t_snoop();
      t_modes();
      report_and_stop();
   end
endmodule
